// *** hdl/stp_cfg.svh ***
// register offsets, field positions and timing constants of the shared timer prescaler
`ifndef STP_CFG_SVH
`define STP_CFG_SVH
`define STP_GTC_DATA_ADDR   8'h43
`define STP_GTC_PORT_ADDR   8'h23
`define STP_PORT_OFFSET     8'h20
`define STP_GTC_RESET       8'h00
`define STP_BIT_SYNC_HOLD   7
`define STP_BIT_ASYNC_RST   1
`define STP_BIT_SHARED_RST  0
`define STP_CS_STOP         3'h0
`define STP_CS_DIRECT       3'h1
`define STP_CS_DIV8         3'h2
`define STP_CS_DIV64        3'h3
`define STP_CS_DIV256       3'h4
`define STP_CS_DIV1024      3'h5
`define STP_CS_EXT_FALL     3'h6
`define STP_CS_EXT_RISE     3'h7
`define STP_DIV_W           10
`define STP_DIV_ZERO        10'h000
`define STP_DIV_ONE         10'h001
`define STP_TAP8_MASK       10'h007
`define STP_TAP64_MASK      10'h03F
`define STP_TAP256_MASK     10'h0FF
`define STP_TAP1024_MASK    10'h3FF
`define STP_NUM_TIMERS      4
`endif

// *** hdl/stp_pkg.sv ***
// types of the shared timer prescaler
package stp_pkg;
    typedef logic [2:0] stp_sel_t;

    typedef struct packed {
        logic       syncHold;
        logic       asyncRst;
        logic       sharedRst;
    } stp_ctrl_t;

    typedef struct packed {
        logic [9:0] divCount;
        stp_ctrl_t  ctrl;
        logic       pinSync1;
        logic       pinSync2;
        logic       pinPrev;
        logic [3:0] countPulse;
        logic       asyncRstOut;
    } stp_state_t;

    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic       portSpace;
        logic [7:0] addr;
        logic [7:0] wrData;
    } stp_bus_t;
endpackage

// *** hdl/shared_timer_prescaler.sv ***
// shared prescaler, external count pin sampling and clock select for four timers
`include "stp_cfg.svh"
module shared_timer_prescaler
    import stp_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire stp_bus_t               bus,
    output logic [7:0]                  rdData,
    input  wire stp_sel_t [3:0]         clockSourceSelect,
    input  wire logic [3:0]             pinForTimer,
    input  wire logic [1:0]             externalCountPin,
    input  wire logic                   asyncTimerMode,
    input  wire logic                   asyncResetDone,
    output logic [3:0]                  timerCountPulse,
    output logic                        asyncDividerReset,
    output logic [9:0]                  dividerValue
);

    ////////////////////////////////////////////////////////////////////////////
    stp_state_t stateFf;
    stp_state_t nxtState;
    logic       hit;
    logic       wrCtrl;
    logic [1:0] pinRise;
    logic [1:0] pinFall;
    logic       divReset;
    logic [1:0] syncA;
    logic [1:0] syncB;
    logic [1:0] prevQ;

    // a tap fires when the low bits of the running divider wrap to zero
    function automatic logic tapFires(input logic [9:0] cnt, input logic [9:0] mask);
        tapFires = ((cnt & mask) == (mask & `STP_DIV_ZERO));
    endfunction

    function automatic logic regHit(input stp_bus_t b);
        if (b.portSpace) begin
            regHit = (b.addr == `STP_GTC_PORT_ADDR) && (b.addr + `STP_PORT_OFFSET == `STP_GTC_DATA_ADDR);
        end else begin
            regHit = (b.addr == `STP_GTC_DATA_ADDR);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // two pins are held as separate synchroniser chains outside the state struct
    logic [1:0] pinSyncFirstFf;
    logic [1:0] pinSyncSecondFf;
    logic [1:0] pinPrevFf;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pinSyncFirstFf  <= 2'h0;
            pinSyncSecondFf <= 2'h0;
            pinPrevFf       <= 2'h0;
        end else begin
            pinSyncFirstFf  <= externalCountPin;
            pinSyncSecondFf <= pinSyncFirstFf;
            pinPrevFf       <= pinSyncSecondFf;
        end
    end

    assign syncA   = pinSyncSecondFf;
    assign syncB   = pinPrevFf;
    assign prevQ   = syncB;
    assign pinRise = syncA & ~prevQ;
    assign pinFall = ~syncA & prevQ;

    ////////////////////////////////////////////////////////////////////////////
    assign hit      = regHit(bus);
    assign wrCtrl   = bus.wrEn && hit;
    assign divReset = stateFf.ctrl.sharedRst;

    always_comb begin
        nxtState = stateFf;
        // free-running divider, only the shared reset bit restarts it
        if (divReset) begin
            nxtState.divCount = `STP_DIV_ZERO;
        end else begin
            nxtState.divCount = stateFf.divCount + `STP_DIV_ONE;
        end

        // control register: hold mode keeps reset bits, otherwise sharedRst self-clears and asyncRst clears unless an async reset is still pending
        if (wrCtrl) begin
            nxtState.ctrl.syncHold  = bus.wrData[`STP_BIT_SYNC_HOLD];
            nxtState.ctrl.sharedRst = bus.wrData[`STP_BIT_SHARED_RST];
            nxtState.ctrl.asyncRst  = bus.wrData[`STP_BIT_ASYNC_RST];
            if (!bus.wrData[`STP_BIT_SYNC_HOLD]) begin
                nxtState.ctrl.sharedRst = bus.wrData[`STP_BIT_SHARED_RST] && !stateFf.ctrl.syncHold;
                nxtState.ctrl.asyncRst  = bus.wrData[`STP_BIT_ASYNC_RST] && !stateFf.ctrl.syncHold;
            end
        end else if (!stateFf.ctrl.syncHold) begin
            nxtState.ctrl.sharedRst = 1'b0;
            if (!asyncTimerMode || asyncResetDone) begin
                nxtState.ctrl.asyncRst = 1'b0;
            end
        end

        // per-timer clock select into a one-cycle count enable
        for (int t = 0; t < `STP_NUM_TIMERS; t++) begin
            logic ext;
            logic rise;
            logic fall;
            ext  = 1'b0;
            rise = pinRise[pinForTimer[t]];
            fall = pinFall[pinForTimer[t]];
            case (clockSourceSelect[t])
                `STP_CS_STOP:     ext = 1'b0;
                `STP_CS_DIRECT:   ext = 1'b1;
                `STP_CS_DIV8:     ext = !divReset && tapFires(stateFf.divCount, `STP_TAP8_MASK);
                `STP_CS_DIV64:    ext = !divReset && tapFires(stateFf.divCount, `STP_TAP64_MASK);
                `STP_CS_DIV256:   ext = !divReset && tapFires(stateFf.divCount, `STP_TAP256_MASK);
                `STP_CS_DIV1024:  ext = !divReset && tapFires(stateFf.divCount, `STP_TAP1024_MASK);
                `STP_CS_EXT_FALL: ext = fall;
                `STP_CS_EXT_RISE: ext = rise;
                default:          ext = 1'b0;
            endcase
            nxtState.countPulse[t] = ext;
        end
        nxtState.asyncRstOut = nxtState.ctrl.asyncRst;
        nxtState.pinSync1    = 1'b0;
        nxtState.pinSync2    = 1'b0;
        nxtState.pinPrev     = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            stateFf <= '0;
        end else begin
            stateFf <= nxtState;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign timerCountPulse   = stateFf.countPulse;
    assign asyncDividerReset = stateFf.asyncRstOut;
    assign dividerValue      = stateFf.divCount;

    always_comb begin
        rdData = `STP_GTC_RESET;
        if (bus.rdEn && hit) begin
            rdData[`STP_BIT_SYNC_HOLD]  = stateFf.ctrl.syncHold;
            rdData[`STP_BIT_ASYNC_RST]  = stateFf.ctrl.asyncRst;
            rdData[`STP_BIT_SHARED_RST] = stateFf.ctrl.sharedRst;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence holdWrite_s;
        wrCtrl && bus.wrData[`STP_BIT_SYNC_HOLD] && bus.wrData[`STP_BIT_SHARED_RST];
    endsequence

    sequence holdKept_s;
        stateFf.ctrl.sharedRst && stateFf.ctrl.syncHold;
    endsequence

    hold_keeps_a: assert property (@(posedge clk) disable iff (!resetn)
        holdWrite_s |=> holdKept_s ##1 (stateFf.ctrl.sharedRst || wrCtrl || $past(wrCtrl)))
        else $error("held divider reset bit dropped");

    release_clears_a: assert property (@(posedge clk) disable iff (!resetn)
        (wrCtrl && !bus.wrData[`STP_BIT_SYNC_HOLD] && stateFf.ctrl.syncHold)
        |=> !stateFf.ctrl.sharedRst && !stateFf.ctrl.asyncRst)
        else $error("reset bits not cleared on hold release");

    shared_selfclear_a: assert property (@(posedge clk) disable iff (!resetn)
        (stateFf.ctrl.sharedRst && !stateFf.ctrl.syncHold && !wrCtrl) |=> !stateFf.ctrl.sharedRst)
        else $error("shared reset bit did not clear");

    divider_restart_a: assert property (@(posedge clk) disable iff (!resetn)
        stateFf.ctrl.sharedRst |=> stateFf.divCount == `STP_DIV_ZERO)
        else $error("divider not restarted");

    divider_runs_a: assert property (@(posedge clk) disable iff (!resetn)
        !stateFf.ctrl.sharedRst |=> stateFf.divCount == $past(stateFf.divCount) + `STP_DIV_ONE)
        else $error("divider stalled");

    direct_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
        clockSourceSelect[0] == `STP_CS_DIRECT |=> timerCountPulse[0])
        else $error("direct clock select gave no pulse");

    ////////////////////////////////////////////////////////////////////////////
    // a tap pulse is launched from divider value zero, so the divider shows one when the pulse is seen
    sequence tap8Seen_s;
        $past(clockSourceSelect[0]) == `STP_CS_DIV8 && timerCountPulse[0];
    endsequence

    sequence tap64Seen_s;
        $past(clockSourceSelect[2]) == `STP_CS_DIV64 && timerCountPulse[2];
    endsequence

    sequence tap256Seen_s;
        $past(clockSourceSelect[3]) == `STP_CS_DIV256 && timerCountPulse[3];
    endsequence

    sequence tap1024Seen_s;
        $past(clockSourceSelect[3]) == `STP_CS_DIV1024 && timerCountPulse[3];
    endsequence

    tap8_period_a: assert property (@(posedge clk) disable iff (!resetn)
        tap8Seen_s |-> (stateFf.divCount & `STP_TAP8_MASK) == `STP_DIV_ONE)
        else $error("divide by 8 tap out of phase");

    tap64_period_a: assert property (@(posedge clk) disable iff (!resetn)
        tap64Seen_s |-> (stateFf.divCount & `STP_TAP64_MASK) == `STP_DIV_ONE)
        else $error("divide by 64 tap out of phase");

    tap256_period_a: assert property (@(posedge clk) disable iff (!resetn)
        tap256Seen_s |-> (stateFf.divCount & `STP_TAP256_MASK) == `STP_DIV_ONE)
        else $error("divide by 256 tap out of phase");

    tap1024_period_a: assert property (@(posedge clk) disable iff (!resetn)
        tap1024Seen_s |-> (stateFf.divCount & `STP_TAP1024_MASK) == `STP_DIV_ONE)
        else $error("divide by 1024 tap out of phase");

    ////////////////////////////////////////////////////////////////////////////
    // stopped timers and timers on a held divider get no count enable
    stop_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
        clockSourceSelect[3] == `STP_CS_STOP |=> !timerCountPulse[3])
        else $error("stopped timer was pulsed");

    reset_suppress_a: assert property (@(posedge clk) disable iff (!resetn)
        (stateFf.ctrl.sharedRst && clockSourceSelect[1] >= `STP_CS_DIV8 && clockSourceSelect[1] <= `STP_CS_DIV1024)
        |=> !timerCountPulse[1])
        else $error("tap pulsed while divider reset");

    sequence relWrite_s;
        wrCtrl && !bus.wrData[`STP_BIT_SYNC_HOLD] && stateFf.ctrl.syncHold && stateFf.ctrl.sharedRst;
    endsequence

    release_together_a: assert property (@(posedge clk) disable iff (!resetn)
        relWrite_s |=> (stateFf.divCount == `STP_DIV_ZERO && !stateFf.ctrl.sharedRst) ##1
        stateFf.divCount == `STP_DIV_ONE)
        else $error("divider did not restart on hold release");

    async_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
        (wrCtrl && bus.wrData[`STP_BIT_ASYNC_RST] && !bus.wrData[`STP_BIT_SYNC_HOLD] &&
        !stateFf.ctrl.syncHold && !asyncTimerMode)
        |=> asyncDividerReset ##1 (!stateFf.ctrl.asyncRst || $past(wrCtrl) || $past(asyncTimerMode)))
        else $error("async divider reset not a single pulse");

    ////////////////////////////////////////////////////////////////////////////
    // external pin edges reach the counters undivided
    ext_fall_a: assert property (@(posedge clk) disable iff (!resetn)
        ($fell(externalCountPin[0]) && clockSourceSelect[2] == `STP_CS_EXT_FALL && pinForTimer[2] == 1'b0)
        ##1 (clockSourceSelect[2] == `STP_CS_EXT_FALL) [*3] |-> timerCountPulse[2])
        else $error("falling pin edge not counted in time");

    ext_rise_other_a: assert property (@(posedge clk) disable iff (!resetn)
        ($rose(externalCountPin[1]) && clockSourceSelect[1] == `STP_CS_EXT_RISE && pinForTimer[1] == 1'b1)
        ##1 (clockSourceSelect[1] == `STP_CS_EXT_RISE) [*3] |-> timerCountPulse[1])
        else $error("rising edge of second pin not counted");

    ext_once_a: assert property (@(posedge clk) disable iff (!resetn)
        (timerCountPulse[0] && $past(clockSourceSelect[0]) == `STP_CS_EXT_RISE &&
        clockSourceSelect[0] == `STP_CS_EXT_RISE) |=> !timerCountPulse[0])
        else $error("one pin edge gave two pulses");

    port_alias_a: assert property (@(posedge clk) disable iff (!resetn)
        (bus.rdEn && bus.portSpace && bus.addr == `STP_GTC_PORT_ADDR)
        |-> rdData[`STP_BIT_SYNC_HOLD] == stateFf.ctrl.syncHold)
        else $error("port address read differs from register");

    ext_rise_a: assert property (@(posedge clk) disable iff (!resetn)
        ($rose(externalCountPin[0]) && clockSourceSelect[0] == `STP_CS_EXT_RISE && pinForTimer[0] == 1'b0)
        ##1 (clockSourceSelect[0] == `STP_CS_EXT_RISE) [*3] |-> timerCountPulse[0])
        else $error("rising pin edge not counted in time");

    async_pending_a: assert property (@(posedge clk) disable iff (!resetn)
        (stateFf.ctrl.asyncRst && asyncTimerMode && !asyncResetDone && !wrCtrl) |=> stateFf.ctrl.asyncRst)
        else $error("async reset bit cleared before completion");
endmodule

// *** testbench/stp_timer_model.sv ***
// partner model: timer count units and the two external count pins
module stp_timer_model
    import stp_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  timerCountPulse,
    output logic [1:0]       externalCountPin,
    output logic [15:0]      pulseCount [4]
);
    timeunit 1ns;
    timeprecision 1ns;
    // pin 1 is always the inverse of pin 0
    initial externalCountPin = 2'h2;
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            pulseCount[i] <= resetn ? pulseCount[i] + 16'(timerCountPulse[i]) : 16'h0000;
        end
    end
    ////////////////////////////////////////////////////////////////
    // n full periods, each half lasting half cycles
    task automatic extPulses(input int n, input int half);
        repeat (n) begin
            repeat (half) @(negedge clk);
            externalCountPin = 2'h1;
            repeat (half) @(negedge clk);
            externalCountPin = 2'h2;
        end
    endtask
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench of the shared timer prescaler
`include "stp_cfg.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import stp_pkg::*;
    logic             clk;
    logic             resetn;
    stp_bus_t         bus;
    logic [7:0]       rdData;
    stp_sel_t [3:0]   sel;
    logic [3:0]       pinForTimer;
    logic [1:0]       pins;
    logic             asyncTimerMode;
    logic             asyncResetDone;
    logic [3:0]       pulses;
    logic             asyncOut;
    logic [9:0]       dividerValue;
    logic [15:0]      pulseCount [4];
    int               errors;
    int               checksDone;
    int               n;

    shared_timer_prescaler DUT (.clk(clk), .resetn(resetn), .bus(bus), .rdData(rdData),
        .clockSourceSelect(sel), .pinForTimer(pinForTimer), .externalCountPin(pins),
        .asyncTimerMode(asyncTimerMode), .asyncResetDone(asyncResetDone), .timerCountPulse(pulses),
        .asyncDividerReset(asyncOut), .dividerValue(dividerValue));
    stp_timer_model model (.clk(clk), .resetn(resetn), .timerCountPulse(pulses),
        .externalCountPin(pins), .pulseCount(pulseCount));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        if (errors == 0 && checksDone > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checksDone++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic p);
        bus = '{1'b1, 1'b0, p, a, d};
        @(negedge clk);
        bus.wrEn = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic p, input logic [7:0] exp);
        bus = '{1'b0, 1'b1, p, a, 8'h00};
        #1;
        cmp("read data", {8'h00, exp}, {8'h00, rdData});
        @(negedge clk);
        bus.rdEn = 1'b0;
        @(negedge clk);
    endtask
    // count pulses of every timer over cyc cycles, optionally preceded by ext external periods
    task automatic measure(input stp_sel_t [3:0] s, input int cyc, input int ext, input logic [63:0] e);
        logic [15:0] base [4];
        sel = s;
        repeat (4) @(negedge clk);
        base = pulseCount;
        if (ext > 0) model.extPulses(ext, 3);
        repeat (cyc) @(negedge clk);
        for (int i = 0; i < 4; i++) cmp("pulse count", e[16*i +: 16], pulseCount[i] - base[i]);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        #300000;
        errors++;
        tally_and_finish();
    end
    initial begin
        {resetn, bus, sel, pinForTimer, asyncTimerMode, asyncResetDone} = '0;
        errors = 0;
        checksDone = 0;
        repeat (6) @(negedge clk);
        resetn = 1'b1;
        rd(`STP_GTC_DATA_ADDR, 1'b0, `STP_GTC_RESET);
        // taps and direct clock, each timer on its own select
        measure({`STP_CS_DIV256, `STP_CS_DIV64, `STP_CS_DIV8, `STP_CS_DIRECT}, 2048, 0,
            {16'd8, 16'd32, 16'd256, 16'd2048});
        measure({`STP_CS_DIV1024, `STP_CS_STOP, `STP_CS_DIV8, `STP_CS_DIV8}, 2048, 0,
            {16'd2, 16'd0, 16'd256, 16'd256});
        // shared divider reset without hold
        wr(`STP_GTC_DATA_ADDR, 8'h01, 1'b0);
        cmp("divider after reset", 16'h0000, {6'h00, dividerValue});
        n = 0;
        while (pulses[0] !== 1'b1 && n < 12) begin
            @(posedge clk);
            #1;
            n++;
        end
        cmp("first tap count in range", 16'h0001, {15'h0000, n >= 1 && n <= 9});
        @(negedge clk);
        rd(`STP_GTC_DATA_ADDR, 1'b0, 8'h00);
        // hold mode keeps both resets, unused bits read zero
        wr(`STP_GTC_DATA_ADDR, 8'hFF, 1'b0);
        rd(`STP_GTC_DATA_ADDR, 1'b0, 8'h83);
        rd(`STP_GTC_PORT_ADDR, 1'b1, 8'h83);
        rd(`STP_GTC_PORT_ADDR, 1'b0, 8'h00);
        rd(8'h44, 1'b0, 8'h00);
        measure({4{`STP_CS_DIV8}}, 40, 0, 64'h0);
        cmp("divider held", 16'h0000, {6'h00, dividerValue});
        wr(`STP_GTC_DATA_ADDR, 8'h00, 1'b0);
        rd(`STP_GTC_DATA_ADDR, 1'b0, 8'h00);
        measure({4{`STP_CS_DIV8}}, 64, 0, {4{16'd8}});
        // external pins: rising on pin 0 for timer 0 and on inverted pin 1 for timer 1, falling on pin 0 for timer 2, never divided
        pinForTimer = 4'b0010;
        measure({`STP_CS_STOP, `STP_CS_EXT_FALL, `STP_CS_EXT_RISE, `STP_CS_EXT_RISE}, 5, 5,
            {16'd0, 16'd5, 16'd5, 16'd5});
        fork
            model.extPulses(1, 3);
            begin
                @(posedge pins[0]);
                n = 0;
                while (pulses[0] !== 1'b1 && n < 10) begin
                    @(posedge clk);
                    #1;
                    n++;
                end
            end
        join
        cmp("edge latency in range", 16'h0001, {15'h0000, n >= 3 && n <= 4});
        @(negedge clk);
        // asynchronous divider reset waits for completion
        asyncTimerMode = 1'b1;
        wr(`STP_GTC_DATA_ADDR, 8'h02, 1'b0);
        repeat (3) @(negedge clk);
        rd(`STP_GTC_DATA_ADDR, 1'b0, 8'h02);
        cmp("async reset out", 16'h0001, {15'h0000, asyncOut});
        asyncResetDone = 1'b1;
        repeat (2) @(negedge clk);
        rd(`STP_GTC_DATA_ADDR, 1'b0, 8'h00);
        cmp("async reset out", 16'h0000, {15'h0000, asyncOut});
        {asyncTimerMode, asyncResetDone} = 2'b00;
        wr(`STP_GTC_DATA_ADDR, 8'h02, 1'b0);
        @(negedge clk);
        rd(`STP_GTC_DATA_ADDR, 1'b0, 8'h00);
        tally_and_finish();
    end
endmodule
